//--- rtl/sar_converter_sequencer.sv
// sequencer for an eight-input successive-approximation converter
// Functional notes
// - select one of eight inputs, or one of four differential pairs
// - every conversion yields a twelve-bit result
// - conversion finishes and result is ready within fifteen microseconds
// - an external start trigger can begin a conversion
// - after a start, wait the programmed delay before sampling
// - done is pollable; interrupt raised when enabled
// - single-ended mode converts the chosen input once, then stops
// - differential mode converts the chosen pair once, then stops
// - positive reference: analog supply, reference pin, input zero or three
// - negative reference: analog supply, input one or input two
// - low-impedance drivers on inputs zero to three bias a touchscreen
// - pen-down is detected and shown to software
// - mux output and converter input can be routed to pins
`timescale 1ns/10ps
module sar_converter_sequencer #(
  parameter int RESULT_W = sar_pkg::RESULT_WIDTH
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire sar_pkg::conv_cfg_t  i_cfg,
  input  wire logic                i_sw_start,
  input  wire logic                i_ext_trigger,
  input  wire logic                i_comparator,
  input  wire logic                i_pen_sense,
  output sar_pkg::analog_ctl_t     o_analog,
  output logic [RESULT_W-1:0]      o_result,
  output logic                     o_done,
  output logic                     o_busy,
  output logic                     o_irq,
  output logic                     o_pen_down
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    sar_pkg::seq_state_t state;
    logic [13:0]         cnt;
    logic [3:0]          bit_idx;
    logic [11:0]         trial;
    logic [11:0]         result;
    logic                done;
    logic                trig_prev;
    logic                pen_down;
    logic                differential;
    logic [2:0]          channel;
  } seq_st_t;

  seq_st_t st_reg;
  seq_st_t st_next;

  logic trig_lvl;
  logic comp_lvl;
  logic pen_lvl;
  logic trig_rise;
  logic start_req;

  sync3 u_sync_trig (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_ext_trigger),
    .o_level   (trig_lvl)
  );

  sync3 u_sync_pen (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_pen_sense),
    .o_level   (pen_lvl)
  );

  // comparator is sampled directly: its bit window is long and a three-stage
  // delay would eat into it, so the sar loop allows for it in BIT_CYCLES
  assign comp_lvl  = i_comparator;

  assign trig_rise = trig_lvl & ~st_reg.trig_prev;
  assign start_req = i_sw_start | (i_cfg.ext_trig_enable & trig_rise);

  function automatic logic [7:0] onehot8(input logic [2:0] idx);
    onehot8 = 8'h01 << idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    st_next           = st_reg;
    st_next.trig_prev = trig_lvl;
    st_next.pen_down  = i_cfg.touch_enable & pen_lvl;
    case (st_reg.state)
      sar_pkg::ST_IDLE: begin
        if (start_req) begin
          // latch selection so a late change cannot corrupt this conversion
          st_next.differential = i_cfg.differential;
          st_next.channel      = i_cfg.channel;
          st_next.done         = 1'b0;
          st_next.cnt          = {6'h00, i_cfg.start_delay};
          st_next.state        = (i_cfg.start_delay == 8'h00) ?
                                 sar_pkg::ST_SAMPLE : sar_pkg::ST_DELAY;
          if (i_cfg.start_delay == 8'h00) begin
            st_next.cnt = 14'(sar_pkg::SAMPLE_CYCLES - 1);
          end
        end
      end
      sar_pkg::ST_DELAY: begin
        if (st_reg.cnt <= 14'h0001) begin
          st_next.state = sar_pkg::ST_SAMPLE;
          st_next.cnt   = 14'(sar_pkg::SAMPLE_CYCLES - 1);
        end else begin
          st_next.cnt = st_reg.cnt - 14'h0001;
        end
      end
      sar_pkg::ST_SAMPLE: begin
        if (st_reg.cnt == 14'h0000) begin
          st_next.state   = sar_pkg::ST_CONV;
          st_next.bit_idx = sar_pkg::BIT_RESET;
          st_next.trial   = 12'h800;
          st_next.cnt     = 14'(sar_pkg::BIT_CYCLES - 1);
        end else begin
          st_next.cnt = st_reg.cnt - 14'h0001;
        end
      end
      sar_pkg::ST_CONV: begin
        if (st_reg.cnt != 14'h0000) begin
          st_next.cnt = st_reg.cnt - 14'h0001;
        end else begin
          // comparator high means input above trial: keep the bit
          st_next.trial[st_reg.bit_idx] = comp_lvl;
          st_next.cnt = 14'(sar_pkg::BIT_CYCLES - 1);
          if (st_reg.bit_idx == 4'h0) begin
            st_next.result = {st_reg.trial[11:1], comp_lvl};
            st_next.done   = 1'b1;
            st_next.state  = sar_pkg::ST_IDLE;
          end else begin
            st_next.bit_idx                    = st_reg.bit_idx - 4'h1;
            st_next.trial[st_reg.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = sar_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg.state        <= sar_pkg::ST_IDLE;
      st_reg.cnt          <= sar_pkg::CNT_RESET;
      st_reg.bit_idx      <= sar_pkg::BIT_RESET;
      st_reg.trial        <= sar_pkg::RESULT_RESET;
      st_reg.result       <= sar_pkg::RESULT_RESET;
      st_reg.done         <= 1'b0;
      st_reg.trig_prev    <= 1'b0;
      st_reg.pen_down     <= 1'b0;
      st_reg.differential <= 1'b0;
      st_reg.channel      <= 3'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls

  logic conv_active;
  assign conv_active = (st_reg.state != sar_pkg::ST_IDLE);

  always_comb begin
    o_analog = '0;
    if (st_reg.differential) begin
      // pair n uses inputs 2n and 2n+1
      o_analog.chan_sel = onehot8({st_reg.channel[1:0], 1'b0}) |
                          onehot8({st_reg.channel[1:0], 1'b1});
    end else begin
      o_analog.chan_sel = onehot8(st_reg.channel);
    end
    o_analog.pos_ref_sel   = 4'h1 << i_cfg.pos_ref;
    case (i_cfg.neg_ref)
      sar_pkg::NREF_INPUT_ONE: o_analog.neg_ref_sel = 3'h2;
      sar_pkg::NREF_INPUT_TWO: o_analog.neg_ref_sel = 3'h4;
      default:                 o_analog.neg_ref_sel = 3'h1;
    endcase
    o_analog.mux_out_route = i_cfg.mux_route_enable;
    o_analog.adc_in_route  = i_cfg.mux_route_enable;
    if (i_cfg.touch_enable) begin
      // axis 0 biases x plates (0 high, 2 low), axis 1 biases y (1 high, 3 low)
      case (i_cfg.touch_axis)
        2'h0: begin
          o_analog.drive_high = 4'h1;
          o_analog.drive_low  = 4'h4;
        end
        2'h1: begin
          o_analog.drive_high = 4'h2;
          o_analog.drive_low  = 4'h8;
        end
        default: begin
          // pen sense: one plate pulled low, the other weakly sensed
          o_analog.drive_high = 4'h0;
          o_analog.drive_low  = 4'h8;
        end
      endcase
    end
    o_analog.sample_hold = (st_reg.state == sar_pkg::ST_SAMPLE);
  end

  assign o_result   = st_reg.result;
  assign o_done     = st_reg.done;
  assign o_busy     = conv_active;
  assign o_irq      = st_reg.done & i_cfg.irq_enable;
  assign o_pen_down = st_reg.pen_down;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [13:0] conv_age;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_age <= 14'h0000;
    end else if (st_reg.state == sar_pkg::ST_SAMPLE || st_reg.state == sar_pkg::ST_CONV) begin
      conv_age <= conv_age + 14'h0001;
    end else begin
      conv_age <= 14'h0000;
    end
  end

  a_conv_time_bound: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_age <= 14'(sar_pkg::CONV_MAX_CYCLES))
    else $error("conversion exceeds time bound");

  a_start_clears_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.state == sar_pkg::ST_IDLE && start_req) |=> !o_done && o_busy)
    else $error("start did not clear done");

  a_result_held: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!o_busy && !$rose(o_done)) |=> $stable(o_result) || $rose(o_done))
    else $error("result changed while idle");

  a_stop_after_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_done) |-> !o_busy)
    else $error("converter did not stop");

  a_irq_gating: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_irq == (o_done && i_cfg.irq_enable))
    else $error("interrupt gating wrong");

  a_delay_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.state == sar_pkg::ST_IDLE && start_req && i_cfg.start_delay == 8'h02)
    |=> !o_analog.sample_hold ##1 !o_analog.sample_hold ##1 o_analog.sample_hold)
    else $error("start delay not honoured");

  a_ext_trigger: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.state == sar_pkg::ST_IDLE && i_cfg.ext_trig_enable && trig_rise) |=> o_busy)
    else $error("trigger ignored");

  a_diff_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_busy && st_reg.differential) |-> $countones(o_analog.chan_sel) == 2)
    else $error("differential pair not selected");

  a_single_chan: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_busy && !st_reg.differential) |-> $onehot(o_analog.chan_sel))
    else $error("single channel not one-hot");

  a_pen_report: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_cfg.touch_enable |=> !o_pen_down)
    else $error("pen-down shown while touch off");

  a_done_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_done && !(st_reg.state == sar_pkg::ST_IDLE && start_req)) |=> o_done)
    else $error("done dropped without a start");

  a_end_with_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_busy) |-> o_done)
    else $error("conversion ended without done");

  a_pos_ref_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $onehot(o_analog.pos_ref_sel))
    else $error("positive reference not one-hot");

  a_neg_ref_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $onehot(o_analog.neg_ref_sel))
    else $error("negative reference not one-hot");

  a_drive_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_cfg.touch_enable |-> (o_analog.drive_high | o_analog.drive_low) == 4'h0)
    else $error("touch driver on while touch off");

  a_drive_clash: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_analog.drive_high & o_analog.drive_low) == 4'h0)
    else $error("touch plate driven both ways");

  c_single_conv: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_done) && !st_reg.differential);
  c_diff_conv: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_done) && st_reg.differential);
  c_ext_start: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cfg.ext_trig_enable && trig_rise && !o_busy);
  c_pen_down: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_pen_down));
  c_touch_bias: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cfg.touch_enable && i_cfg.touch_axis == 2'h1 && o_pen_down);
endmodule

//--- rtl/sar_pkg.sv
// shared types and constants for the sar converter sequencer
package sar_pkg;
  localparam int          RESULT_WIDTH      = 12;
  localparam int          CHAN_WIDTH        = 3;
  localparam int          PAIR_WIDTH        = 2;
  localparam int          CLK_PERIOD_PS     = 4000;
  localparam int          CONV_TIME_US      = 15;
  // longest time rounds down
  localparam int          CONV_MAX_CYCLES   = (CONV_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int          SAMPLE_CYCLES     = 64;
  localparam int          BIT_CYCLES        = 16;
  localparam logic [7:0]  DELAY_RESET       = 8'h00;
  localparam logic [11:0] RESULT_RESET      = 12'h000;
  localparam logic [13:0] CNT_RESET         = 14'h0000;
  localparam logic [3:0]  BIT_RESET         = 4'hb;

  typedef enum logic [1:0] {
    PREF_ANALOG_SUPPLY = 2'h0,
    PREF_EXT_PIN       = 2'h1,
    PREF_INPUT_ZERO    = 2'h2,
    PREF_INPUT_THREE   = 2'h3
  } pos_ref_t;

  typedef enum logic [1:0] {
    NREF_ANALOG_SUPPLY = 2'h0,
    NREF_INPUT_ONE     = 2'h1,
    NREF_INPUT_TWO     = 2'h2
  } neg_ref_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_DELAY  = 4'h2,
    ST_SAMPLE = 4'h4,
    ST_CONV   = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic       differential;
    logic [2:0] channel;
    pos_ref_t   pos_ref;
    neg_ref_t   neg_ref;
    logic [7:0] start_delay;
    logic       irq_enable;
    logic       ext_trig_enable;
    logic       mux_route_enable;
    logic       touch_enable;
    logic [1:0] touch_axis;
  } conv_cfg_t;

  typedef struct packed {
    logic [7:0] chan_sel;
    logic [3:0] pos_ref_sel;
    logic [2:0] neg_ref_sel;
    logic       mux_out_route;
    logic       adc_in_route;
    logic [3:0] drive_high;
    logic [3:0] drive_low;
    logic       sample_hold;
  } analog_ctl_t;
endpackage

//--- rtl/sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module sync3 (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_st_t;

  sync_st_t st_reg;
  sync_st_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.s1  = i_async;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    // only s2 and s3 are compared, s1 may be metastable
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.lvl;
endmodule

//--- verification/sar_analog_model.sv
// model of the analog side: sensor levels, comparator and touch panel
`timescale 1ns/10ps
module sar_analog_model (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire sar_pkg::analog_ctl_t i_analog,
  input  wire logic [11:0]          i_levels [12],
  input  wire logic                 i_pressed,
  output logic                      o_comparator,
  output logic                      o_pen_sense
);
  logic [7:0]  cnt_reg;
  logic [11:0] level;
  logic [3:0]  bit_idx;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    level = 12'h000;
    for (int i = 0; i < 8; i++) begin
      if (i_analog.chan_sel == (8'h01 << i)) level = i_levels[i];
    end
    for (int p = 0; p < 4; p++) begin
      if (i_analog.chan_sel == (8'h03 << (2 * p))) level = i_levels[8 + p];
    end
  end
  // bit window counted from the end of sampling
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) cnt_reg <= 8'hff;
    else if (i_analog.sample_hold) cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
  end
  assign bit_idx = 4'hb - cnt_reg[7:4];
  // ideal comparator; outside the bit window it wanders so a stray sample shows
  assign o_comparator = (cnt_reg < 8'hc0) ? level[bit_idx] : i_sys_clk;
  assign o_pen_sense  = i_pressed;
endmodule

//--- verification/test_sar_converter_sequencer.sv
// self-checking bench for the sar converter sequencer
`timescale 1ns/10ps
module test_sar_converter_sequencer;
  typedef struct packed {
    logic       diff;
    logic [2:0] chan;
    logic [7:0] delay;
    logic [7:0] exp_sel;
  } row_t;
  localparam row_t ROWS [12] = '{
    '{1'b0, 3'h0, 8'h00, 8'h01}, '{1'b0, 3'h1, 8'h01, 8'h02}, '{1'b0, 3'h2, 8'h02, 8'h04},
    '{1'b0, 3'h3, 8'hff, 8'h08}, '{1'b0, 3'h4, 8'h10, 8'h10}, '{1'b0, 3'h5, 8'h07, 8'h20},
    '{1'b0, 3'h6, 8'h00, 8'h40}, '{1'b0, 3'h7, 8'h03, 8'h80}, '{1'b1, 3'h0, 8'h00, 8'h03},
    '{1'b1, 3'h1, 8'h05, 8'h0c}, '{1'b1, 3'h2, 8'h00, 8'h30}, '{1'b1, 3'h3, 8'h80, 8'hc0}};
  logic [11:0] levels [12] = '{12'h000, 12'hfff, 12'h5a5, 12'ha5a, 12'h123, 12'h800,
                               12'h7ff, 12'h001, 12'hc3c, 12'h3c3, 12'h9e1, 12'h0f0};
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  sar_pkg::conv_cfg_t   cfg = '0;
  logic                 sw_start = 1'b0;
  logic                 ext_trigger = 1'b0;
  logic                 pressed = 1'b0;
  logic                 comparator;
  logic                 pen_sense;
  sar_pkg::analog_ctl_t analog;
  logic [11:0]          result;
  logic                 done;
  logic                 busy;
  logic                 irq;
  logic                 pen_down;
  int                   err_total = 0;
  int                   check_count = 0;
  int                   n;
  // edges from the start edge to done, on top of the programmed delay
  localparam int        BASE_CYCLES = sar_pkg::SAMPLE_CYCLES +
                                      sar_pkg::RESULT_WIDTH * sar_pkg::BIT_CYCLES;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  sar_converter_sequencer u_sar_converter_sequencer (
    .i_sys_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_sw_start(sw_start),
    .i_ext_trigger(ext_trigger), .i_comparator(comparator), .i_pen_sense(pen_sense),
    .o_analog(analog), .o_result(result), .o_done(done), .o_busy(busy), .o_irq(irq),
    .o_pen_down(pen_down));
  sar_analog_model u_sar_analog_model (
    .i_sys_clk(clk), .i_rst(rst), .i_analog(analog), .i_levels(levels),
    .i_pressed(pressed), .o_comparator(comparator), .o_pen_sense(pen_sense));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
    n++;
  endtask
  // a second start is poked at cycle poke while the conversion runs
  task automatic convert(input logic by_pin, input int poke);
    n = 0;
    if (by_pin) ext_trigger = 1'b1;
    else sw_start = 1'b1;
    @(posedge clk);
    #1;
    sw_start = 1'b0;
    // a pin start shows only after the synchroniser, so wait for busy first
    while (busy !== 1'b1 && n < 20) step();
    n = 0;
    check("busy_at_start", 16'h1, busy);
    check("done_cleared", 16'h0, done);
    while (done !== 1'b1 && n < 4000) begin
      step();
      if (n == poke) sw_start = 1'b1;
      else if (n == poke + 1) sw_start = 1'b0;
    end
    ext_trigger = 1'b0;
    check("in_time", 16'h1, 16'(n <= sar_pkg::CONV_MAX_CYCLES));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    #1;
    check("done_rst", 16'h0, done);
    check("busy_rst", 16'h0, busy);
    check("result_rst", 16'h0, result);
    rst = 1'b0;
    for (int r = 0; r < 12; r++) begin
      cfg.differential     = ROWS[r].diff;
      cfg.channel          = ROWS[r].chan;
      cfg.start_delay      = ROWS[r].delay;
      cfg.pos_ref          = sar_pkg::pos_ref_t'(r % 4);
      cfg.neg_ref          = sar_pkg::neg_ref_t'(r % 3);
      cfg.irq_enable       = r[0];
      cfg.mux_route_enable = r[1];
      convert(1'b0, -1);
      check("cycles", 16'(BASE_CYCLES + ROWS[r].delay), 16'(n));
      check("chan_sel", 16'(ROWS[r].exp_sel), 16'(analog.chan_sel));
      check("pos_ref_sel", 16'h1 << (r % 4), 16'(analog.pos_ref_sel));
      check("neg_ref_sel", 16'h1 << (r % 3), 16'(analog.neg_ref_sel));
      check("irq", 16'(r[0]), 16'(irq));
      check("mux_route", {14'h0, r[1], r[1]}, {14'h0, analog.mux_out_route, analog.adc_in_route});
      repeat (6) step();
      check("result", 16'(levels[r]), 16'(result));
      check("idle_after", 16'h2, {14'h0, done, busy});
    end
    // start while busy is ignored, then a start right after done
    cfg = '0;
    convert(1'b0, 100);
    check("refused_cycles", 16'(BASE_CYCLES), 16'(n));
    convert(1'b0, -1);
    check("b2b_cycles", 16'(BASE_CYCLES), 16'(n));
    check("b2b_result", 16'(levels[0]), 16'(result));
    // pin start refused while disabled, then taken
    cfg.channel = 3'h2;
    ext_trigger = 1'b1;
    repeat (20) step();
    check("pin_disabled", 16'h0, busy);
    ext_trigger = 1'b0;
    cfg.ext_trig_enable = 1'b1;
    repeat (4) step();
    convert(1'b1, -1);
    check("pin_result", 16'(levels[2]), 16'(result));
    // touch panel bias and pen-down
    check("no_drive", 16'h0, {8'h0, analog.drive_high, analog.drive_low});
    pressed = 1'b1;
    repeat (10) step();
    check("pen_gated", 16'h0, 16'(pen_down));
    cfg.touch_enable = 1'b1;
    repeat (10) step();
    check("pen_down", 16'h1, 16'(pen_down));
    for (int a = 0; a < 3; a++) begin
      cfg.touch_axis = 2'(a);
      step();
      check("drive_on", 16'h1, 16'((analog.drive_high | analog.drive_low) != 4'h0));
      check("drive_clash", 16'h0, 16'(analog.drive_high & analog.drive_low));
    end
    pressed = 1'b0;
    repeat (10) step();
    check("pen_up", 16'h0, 16'(pen_down));
    print_verdict();
  end
endmodule
